// ---- src/kcl_top.sv ----
// Knife correction command logic with Avalon-MM register slave
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module kcl_top #(
  parameter int unsigned MS_CYCLES = kcl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Encoder channels
  input  wire logic        enc_marker,
  input  wire logic        enc_count,
  // Distance switch banks, bit i is switch i+1, ON is 1
  input  wire logic [7:0]  upper_digit_switch_bank,
  input  wire logic [7:0]  lower_digit_switch_bank,
  // Decision pulses from the comparison stage
  input  wire logic        dec_advance,
  input  wire logic        dec_retard,
  input  wire logic        dec_insync,
  // Push buttons, high while pressed
  input  wire logic        btn_advance,
  input  wire logic        btn_retard,
  // Motor drive stage
  output logic             motor_on,
  output logic             motor_reverse,
  output logic             motor_full_speed,
  output logic             ind_insync,
  output logic             ind_advance,
  output logic             ind_retard,
  output logic             cutline_pulse
);

  // The tick counter is 24 bits wide
  if (MS_CYCLES < 1 || MS_CYCLES > 32'd16777216) begin : g_bad_ms
    $error("kcl_top: MS_CYCLES out of range");
  end

  localparam logic [kcl_pkg::ANGLE_W-1:0] ANGLE_LAST =
    kcl_pkg::ANGLE_W'(kcl_pkg::COUNTS_PER_REV - 1);
  localparam logic [21:0] REV_MOD = 22'(kcl_pkg::COUNTS_PER_REV);
  localparam logic [23:0] TICK_LAST = 24'(MS_CYCLES - 1);

  function automatic logic [kcl_pkg::DIST_W-1:0] bcd_to_tenths(
    input logic [3:0] d3, input logic [3:0] d2,
    input logic [3:0] d1, input logic [3:0] d0);
    bcd_to_tenths = kcl_pkg::DIST_W'(d3 * 1000 + d2 * 100 + d1 * 10 + d0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Encoder front end

  logic [1:0] enc_rise;

  kcl_edge_sync #(.WIDTH(2)) u_enc_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .raw_in    ({enc_marker, enc_count}),
    .level_out (),
    .rise_out  (enc_rise)
  );

  wire marker_rise = enc_rise[1];
  wire count_rise  = enc_rise[0];

  logic [kcl_pkg::ANGLE_W-1:0] angle_q;
  logic [15:0]                 rev_q;

  // Marker wins over a coincident count: it is angle zero, mid-shear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      angle_q <= '0;
      rev_q   <= '0;
    end else if (marker_rise) begin
      angle_q <= '0;
      rev_q   <= rev_q + 16'h0001;
    end else if (count_rise && angle_q != ANGLE_LAST) begin
      angle_q <= angle_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Distance decode and predicted cut-line

  wire [3:0] dig_hund  = upper_digit_switch_bank[7:4];
  wire [3:0] dig_thou  = upper_digit_switch_bank[3:0];
  wire [3:0] dig_units = lower_digit_switch_bank[7:4];
  wire [3:0] dig_tenth = lower_digit_switch_bank[3:0];

  // Upper bank digit order: switches 5-8 are most significant
  wire [kcl_pkg::DIST_W-1:0] dist_tenths =
    bcd_to_tenths(dig_hund, dig_thou, dig_units, dig_tenth);
  // Top nibble holds 0-15 hundreds so that 1599.9 fits; it is never bad
  wire dist_err = (dig_thou > kcl_pkg::BCD_MAX_DIGIT) ||
                  (dig_units > kcl_pkg::BCD_MAX_DIGIT) ||
                  (dig_tenth > kcl_pkg::BCD_MAX_DIGIT);

  logic [15:0] scale_q;
  wire  [29:0] dist_prod = 30'(dist_tenths * scale_q);
  wire  [21:0] dist_cnt  = dist_prod[29:kcl_pkg::SCALE_FRAC];

  // Sequential modulo keeps the divider off the critical path
  logic [21:0]                 mod_src_q;
  logic [21:0]                 mod_rem_q;
  logic [3:0]                  mod_k_q;
  logic [kcl_pkg::ANGLE_W-1:0] cut_pos_q;
  wire  [21:0]                 mod_step = REV_MOD << mod_k_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mod_src_q <= '0;
      mod_rem_q <= '0;
      mod_k_q   <= 4'hc;
      cut_pos_q <= '0;
    end else if (dist_cnt != mod_src_q) begin
      mod_src_q <= dist_cnt;
      mod_rem_q <= dist_cnt;
      mod_k_q   <= 4'hc;
    end else begin
      if (mod_rem_q >= mod_step) begin
        mod_rem_q <= mod_rem_q - mod_step;
      end
      if (mod_k_q != 4'h0) begin
        mod_k_q <= mod_k_q - 4'h1;
      end else if (mod_rem_q < REV_MOD) begin
        cut_pos_q <= mod_rem_q[kcl_pkg::ANGLE_W-1:0];
      end
    end
  end

  logic cutline_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cutline_q <= 1'b0;
    end else begin
      cutline_q <= (marker_rise || count_rise) &&
                   ((marker_rise ? '0 : angle_q + 1'b1) == cut_pos_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command stage

  logic        auto_q;
  logic [15:0] corr_q;
  logic [23:0] tick_cnt_q;
  logic [15:0] ms_left_q;
  logic        run_rev_q;
  logic        ind_ins_q;
  logic        ind_adv_q;
  logic        ind_ret_q;
  logic        mot_on_q;
  logic        mot_rev_q;
  logic        mot_full_q;
  kcl_pkg::kcl_cmd_e state_q;

  wire man_adv  = btn_advance && !btn_retard;
  wire man_ret  = btn_retard && !btn_advance;
  wire manual   = man_adv || man_ret;
  wire tick     = (tick_cnt_q == TICK_LAST);
  wire any_dec  = dec_advance || dec_retard || dec_insync;
  wire take_dec = auto_q && !manual && state_q == kcl_pkg::KCL_IDLE && any_dec;

  always_ff @(posedge core_clk) begin
    if (rst || state_q == kcl_pkg::KCL_IDLE || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end

  // Advance beats retard beats in-sync when pulses coincide
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q   <= kcl_pkg::KCL_IDLE;
      ms_left_q <= '0;
      run_rev_q <= 1'b0;
      ind_ins_q <= 1'b0;
      ind_adv_q <= 1'b0;
      ind_ret_q <= 1'b0;
    end else if (manual) begin
      state_q   <= kcl_pkg::KCL_IDLE;
      ind_ins_q <= 1'b0;
      ind_adv_q <= man_adv;
      ind_ret_q <= man_ret;
    end else begin
      case (state_q)
        kcl_pkg::KCL_IDLE: begin
          if (take_dec) begin
            ind_adv_q <= dec_advance;
            ind_ret_q <= dec_retard && !dec_advance;
            ind_ins_q <= dec_insync && !dec_advance && !dec_retard;
            run_rev_q <= dec_retard && !dec_advance;
            ms_left_q <= corr_q;
            if ((dec_advance || dec_retard) && corr_q != 16'h0000) begin
              state_q <= kcl_pkg::KCL_RUN;
            end
          end
        end
        kcl_pkg::KCL_RUN: begin
          // Decisions arriving here are dropped, not queued
          if (tick) begin
            ms_left_q <= ms_left_q - 16'h0001;
            if (ms_left_q == 16'h0001) begin
              state_q <= kcl_pkg::KCL_IDLE;
            end
          end
        end
        default: state_q <= kcl_pkg::KCL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mot_on_q   <= 1'b0;
      mot_rev_q  <= 1'b0;
      mot_full_q <= 1'b0;
    end else if (manual) begin
      mot_on_q   <= 1'b1;
      mot_rev_q  <= man_ret;
      mot_full_q <= 1'b1;
    end else begin
      mot_on_q   <= (state_q == kcl_pkg::KCL_RUN);
      mot_rev_q  <= run_rev_q;
      mot_full_q <= 1'b0;
    end
  end

  assign motor_on         = mot_on_q;
  assign motor_reverse    = mot_rev_q;
  assign motor_full_speed = mot_full_q;
  assign ind_insync       = ind_ins_q;
  assign ind_advance      = ind_adv_q;
  assign ind_retard       = ind_ret_q;
  assign cutline_pulse    = cutline_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register slave, one wait state per access

  logic        wait_q;
  logic [31:0] rdata_q;

  wire req    = avs_read || avs_write;
  wire accept = req && !wait_q;
  wire wr     = avs_write && accept;
  wire sel_ctrl  = (avs_address == kcl_pkg::OFS_CTRL);
  wire sel_corr  = (avs_address == kcl_pkg::OFS_CORR);
  wire sel_scale = (avs_address == kcl_pkg::OFS_SCALE);
  wire sel_stat  = (avs_address == kcl_pkg::OFS_STATUS);
  wire sel_dist  = (avs_address == kcl_pkg::OFS_DIST);

  logic [31:0] status_w;
  logic [31:0] dist_w;
  logic [31:0] rmux;

  always_comb begin
    status_w = '0;
    status_w[kcl_pkg::ANGLE_W-1:0]   = angle_q;
    status_w[kcl_pkg::ST_BUSY_BIT]   = (state_q == kcl_pkg::KCL_RUN);
    status_w[kcl_pkg::ST_INSYNC_BIT] = ind_ins_q;
    status_w[kcl_pkg::ST_ADV_BIT]    = ind_adv_q;
    status_w[kcl_pkg::ST_RET_BIT]    = ind_ret_q;
    status_w[kcl_pkg::ST_DERR_BIT]   = dist_err;
    status_w[kcl_pkg::ST_MAN_BIT]    = manual;
    status_w[kcl_pkg::ST_REV_LSB +: 16] = rev_q;
    dist_w = '0;
    dist_w[kcl_pkg::DIST_W-1:0] = dist_tenths;
    dist_w[kcl_pkg::DIST_POS_LSB +: kcl_pkg::ANGLE_W] = cut_pos_q;
    if (sel_ctrl) begin
      rmux = {31'h0, auto_q};
    end else if (sel_corr) begin
      rmux = {16'h0, corr_q};
    end else if (sel_scale) begin
      rmux = {16'h0, scale_q};
    end else if (sel_stat) begin
      rmux = status_w;
    end else if (sel_dist) begin
      rmux = dist_w;
    end else begin
      rmux = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q  <= !(req && wait_q);
      if (req && wait_q) begin
        rdata_q <= avs_read ? rmux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      auto_q  <= kcl_pkg::RST_AUTO;
      corr_q  <= kcl_pkg::RST_CORR;
      scale_q <= kcl_pkg::RST_SCALE;
    end else if (wr) begin
      if (sel_ctrl) begin
        auto_q <= avs_writedata[kcl_pkg::CTRL_AUTO_BIT];
      end
      if (sel_corr) begin
        corr_q <= avs_writedata[15:0];
      end
      if (sel_scale) begin
        scale_q <= avs_writedata[15:0];
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule
`default_nettype wire

// ---- src/kcl_pkg.sv ----
// Shared constants for the knife correction command logic
package kcl_pkg;

  // Clock and time base
  localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES  =
    CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;

  // Encoder
  localparam int unsigned COUNTS_PER_REV = 1000;
  localparam int unsigned ANGLE_W        = 10;

  // Distance in tenths of an inch, at most 15999
  localparam int unsigned DIST_W         = 14;
  localparam logic [3:0]  BCD_MAX_DIGIT  = 4'h9;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CORR   = 5'h04;
  localparam logic [4:0] OFS_SCALE  = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_DIST   = 5'h10;

  // Field positions
  localparam int unsigned CTRL_AUTO_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT    = 10;
  localparam int unsigned ST_INSYNC_BIT  = 11;
  localparam int unsigned ST_ADV_BIT     = 12;
  localparam int unsigned ST_RET_BIT     = 13;
  localparam int unsigned ST_DERR_BIT    = 14;
  localparam int unsigned ST_MAN_BIT     = 15;
  localparam int unsigned ST_REV_LSB     = 16;
  localparam int unsigned DIST_POS_LSB   = 16;
  localparam int unsigned SCALE_FRAC     = 8;

  // Values after reset
  localparam logic        RST_AUTO  = 1'b1;
  localparam logic [15:0] RST_CORR  = 16'h0064;
  localparam logic [15:0] RST_SCALE = 16'h0000;

  // Command state
  typedef enum logic [0:0] {
    KCL_IDLE,
    KCL_RUN
  } kcl_cmd_e;

endpackage

// ---- src/kcl_edge_sync.sv ----
// Two-stage synchroniser with rising-edge pulse per bit
`timescale 1ns/1ps
`default_nettype none
module kcl_edge_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Raw and conditioned signals
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("kcl_edge_sync: WIDTH must be at least 1");
  end

  // A narrow marker survives as long as it spans one clock edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;

endmodule
`default_nettype wire

// ---- tb/kcl_checker.sv ----
// Port-level assertions for the knife correction command logic
`timescale 1ns/1ps
`default_nettype none
module kcl_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decisions and buttons
  input wire logic dec_advance,
  input wire logic dec_retard,
  input wire logic dec_insync,
  input wire logic btn_advance,
  input wire logic btn_retard,
  // Motor stage
  input wire logic motor_on,
  input wire logic motor_reverse,
  input wire logic motor_full_speed,
  input wire logic ind_insync,
  input wire logic ind_advance,
  input wire logic ind_retard
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic [2:0] ind = {ind_insync, ind_advance, ind_retard};
  wire logic       quiet = !dec_advance && !dec_retard && !dec_insync;
  wire logic       no_btn = !btn_advance && !btn_retard;

  ind_onehot_a:
    assert property ($onehot0(ind)) else $error("two indicators lit");
  adv_cause_a:
    assert property ($rose(ind_advance)
      |-> $past(dec_advance) || $past(btn_advance))
      else $error("advance lit without cause");
  ret_cause_a:
    assert property ($rose(ind_retard)
      |-> $past(dec_retard) || $past(btn_retard))
      else $error("retard lit without cause");
  sync_cause_a:
    assert property ($rose(ind_insync) |-> $past(dec_insync))
      else $error("in-sync lit without cause");
  motor_dir_a:
    assert property (motor_on
      |-> (ind_advance ^ ind_retard) && motor_reverse == ind_retard)
      else $error("motor polarity wrong");
  manual_run_a:
    assert property (btn_advance && !btn_retard
      |=> motor_on && motor_full_speed && !motor_reverse && ind_advance)
      else $error("manual advance not at full speed");
  manual_stop_a:
    assert property (motor_full_speed && no_btn |=> !motor_on)
      else $error("motor runs after release");
  lockout_a:
    assert property (motor_on && !motor_full_speed && no_btn
      |=> $stable(ind) || !motor_on)
      else $error("command taken during run");
  ind_hold_a:
    assert property (quiet && no_btn |=> $stable(ind))
      else $error("indicator changed without cause");
endmodule
`default_nettype wire

// ---- tb/kcl_enc_model.sv ----
// Behavioural shaft encoder driving the marker and count channels
`timescale 1ns/1ps
`default_nettype none
module kcl_enc_model (
  // Clock of the logic under test
  input  wire logic        core_clk,
  // Run request and count pulses sent after the marker
  input  wire logic        start,
  input  wire logic [10:0] n_counts,
  // Encoder channels
  output logic             enc_marker,
  output logic             enc_count,
  output logic             done
);
  initial begin
    int i;
    enc_marker = 1'b0;
    enc_count  = 1'b0;
    done       = 1'b1;
    forever begin
      @(posedge core_clk);
      if (start) begin
        done <= 1'b0;
        // Two cycles only: the narrowest marker the sync must catch
        enc_marker <= 1'b1;
        repeat (2) @(posedge core_clk);
        enc_marker <= 1'b0;
        // 1000 counts are one whole knife turn
        for (i = 0; i < n_counts; i++) begin
          repeat (2) @(posedge core_clk);
          enc_count <= 1'b1;
          repeat (2) @(posedge core_clk);
          enc_count <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking testbench for the knife correction command logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        enc_marker;
  logic        enc_count;
  logic [7:0]  up_bank;
  logic [7:0]  lo_bank;
  logic [2:0]  dec;
  logic        btn_advance;
  logic        btn_retard;
  logic        motor_on;
  logic        motor_reverse;
  logic        motor_full_speed;
  logic        ind_insync;
  logic        ind_advance;
  logic        ind_retard;
  logic        cutline_pulse;
  logic        enc_start;
  logic [10:0] enc_n;
  logic        enc_done;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cut_n = 0;
  wire logic [2:0] ind = {ind_insync, ind_advance, ind_retard};
  wire logic [2:0] mot = {motor_on, motor_reverse, motor_full_speed};

  kcl_top #(.MS_CYCLES(10)) dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enc_marker(enc_marker),
    .enc_count(enc_count), .upper_digit_switch_bank(up_bank),
    .lower_digit_switch_bank(lo_bank), .dec_advance(dec[2]),
    .dec_retard(dec[1]), .dec_insync(dec[0]),
    .btn_advance(btn_advance), .btn_retard(btn_retard),
    .motor_on(motor_on), .motor_reverse(motor_reverse),
    .motor_full_speed(motor_full_speed), .ind_insync(ind_insync),
    .ind_advance(ind_advance), .ind_retard(ind_retard),
    .cutline_pulse(cutline_pulse));
  kcl_enc_model enc (
    .core_clk(core_clk), .start(enc_start), .n_counts(enc_n),
    .enc_marker(enc_marker), .enc_count(enc_count), .done(enc_done));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (cutline_pulse === 1'b1) cut_n <= cut_n + 1;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1);
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge core_clk);
    dec <= v;
    @(posedge core_clk);
    dec <= 3'b000;
    #1;
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (motor_on !== 1'b0 && n < 200) begin
      step();
      n++;
    end
  endtask
  task automatic spin(input logic [10:0] n);
    int k;
    k = 0;
    @(posedge core_clk);
    enc_n <= n;
    enc_start <= 1'b1;
    @(posedge core_clk);
    enc_start <= 1'b0;
    @(posedge core_clk);
    while (enc_done !== 1'b1 && k < 6000) begin
      @(posedge core_clk);
      k++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    bus(1'b0, kcl_pkg::OFS_CTRL, 32'h0, d);
    chk(d, {31'h0, kcl_pkg::RST_AUTO});
    bus(1'b0, kcl_pkg::OFS_CORR, 32'h0, d);
    chk(d, {16'h0, kcl_pkg::RST_CORR});
    bus(1'b1, 5'h14, 32'h5, d);
    bus(1'b0, 5'h14, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b1, kcl_pkg::OFS_SCALE, 32'h100, d);
    bus(1'b0, kcl_pkg::OFS_SCALE, 32'h0, d);
    chk(d, 32'h100);
    $display("register test done");
  endtask
  task automatic t_dist;
    logic [7:0]  up [5] = '{8'h21, 8'hf9, 8'h00, 8'h00, 8'h12};
    logic [7:0]  lo [5] = '{8'h37, 8'h99, 8'h01, 8'h0a, 8'h34};
    int          ex [5] = '{2137, 15999, 1, 10, 1234};
    logic [31:0] d;
    logic [31:0] x;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      up_bank <= up[i];
      lo_bank <= lo[i];
      repeat (20) @(posedge core_clk);
      bus(1'b0, kcl_pkg::OFS_DIST, 32'h0, d);
      x = {6'h00, 10'(ex[i] % 1000), 2'h0, 14'(ex[i])};
      chk(d & 32'h03ff3fff, x);
      // Only the fourth setting holds a bad digit; the F of the second sits in the top nibble, which is never bad
      bus(1'b0, kcl_pkg::OFS_STATUS, 32'h0, d);
      chk(d[kcl_pkg::ST_DERR_BIT], i == 3);
    end
    $display("distance test done");
  endtask
  task automatic t_enc;
    logic [31:0] d;
    int          c0;
    // Distance stays 123.4 in, so the cut-line sits at angle 234
    c0 = cut_n;
    spin(11'd1000);
    spin(11'd300);
    bus(1'b0, kcl_pkg::OFS_STATUS, 32'h0, d);
    chk(d[9:0], 10'd300);
    chk(d[31:16], 16'h0002);
    chk(cut_n - c0, 2);
    $display("encoder test done");
  endtask
  task automatic t_dec;
    logic [31:0] d;
    int          n;
    bus(1'b1, kcl_pkg::OFS_CORR, 32'h2, d);
    pulse(3'b100);
    chk(ind, 3'b010);
    step();
    chk(mot, 3'b100);
    pulse(3'b010);
    chk(ind, 3'b010);
    wait_idle(n);
    chk(n > 8 && n < 40, 1'b1);
    pulse(3'b011);
    chk(ind, 3'b001);
    step();
    chk(mot, 3'b110);
    wait_idle(n);
    pulse(3'b001);
    chk(ind, 3'b100);
    step();
    chk(mot, 3'b000);
    pulse(3'b111);
    chk(ind, 3'b010);
    step();
    wait_idle(n);
    bus(1'b1, kcl_pkg::OFS_CTRL, 32'h0, d);
    pulse(3'b001);
    chk(ind, 3'b010);
    bus(1'b1, kcl_pkg::OFS_CTRL, 32'h1, d);
    $display("decision test done");
  endtask
  task automatic t_man;
    @(posedge core_clk);
    btn_retard <= 1'b1;
    step();
    chk(mot, 3'b111);
    chk(ind, 3'b001);
    // Both held at once must not drive the motor
    @(posedge core_clk);
    btn_advance <= 1'b1;
    step();
    chk(motor_on, 1'b0);
    @(posedge core_clk);
    btn_retard <= 1'b0;
    step();
    chk(mot, 3'b101);
    @(posedge core_clk);
    btn_advance <= 1'b0;
    step();
    chk(motor_on, 1'b0);
    chk(ind, 3'b010);
    $display("manual test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, btn_advance, btn_retard, enc_start} = '0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    dec = 3'b000;
    enc_n = 11'h000;
    up_bank = 8'h00;
    lo_bank = 8'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_dist();
    t_enc();
    t_dec();
    t_man();
    results();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    results();
  end
endmodule

bind kcl_top kcl_checker chk_i (
  .core_clk(core_clk), .rst(rst), .dec_advance(dec_advance),
  .dec_retard(dec_retard), .dec_insync(dec_insync),
  .btn_advance(btn_advance), .btn_retard(btn_retard),
  .motor_on(motor_on), .motor_reverse(motor_reverse),
  .motor_full_speed(motor_full_speed), .ind_insync(ind_insync),
  .ind_advance(ind_advance), .ind_retard(ind_retard));
`default_nettype wire
